// ---- dv/host_apb_model.sv ----
/*
  Host model: APB master and the control-bit orderings a host keeps.
  Assumes the block answers on the same clock; the bench bounds the run.
*/
`timescale 1ns/10ps
module host_apb_model (
  input wire logic clk,
  output logic [7:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import lmon_pkg::*;
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // ==========================================================
  // bus cycle: request held until pready is seen high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, a, d, rd, err);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [31:0] rd, output logic err);
    xfer(1'b0, a, 32'h0, rd, err);
  endtask
  // ==========================================================
  // caller id capture orderings
  task automatic cid_start(input logic [31:0] base);
    logic [31:0] c;
    c = base | (32'h1 << CTL_RING_RST);
    write_reg(ADDR_CTRL, c);
    c = c | (32'h1 << CTL_LP_MODE);
    write_reg(ADDR_CTRL, c);
    write_reg(ADDR_CTRL, c | (32'h1 << CTL_MON_EN));
  endtask
  task automatic cid_stop(input logic [31:0] base);
    write_reg(ADDR_CTRL, base);
  endtask
  // ==========================================================
  // billing tone release: wait for overload to pass, then disable
  task automatic billing_release(input logic [31:0] base);
    logic [31:0] st;
    logic err;
    read_reg(ADDR_STATUS, st, err);
    while (st[ST_OVL] !== 1'b0) begin
      read_reg(ADDR_STATUS, st, err);
    end
    write_reg(ADDR_CTRL, base & ~(32'h1 << CTL_BT_EN));
  endtask
endmodule

// ---- dv/line_monitor_billing_cid_control_tb_top.sv ----
/*
  Self-checking bench for the line monitor control block.
  Assumes the package and the host model are compiled first.
*/
`timescale 1ns/10ps
module line_monitor_billing_cid_control_tb_top;
  import lmon_pkg::*;
  localparam logic [31:0] MON = 32'h1 << CTL_MON_EN;
  localparam logic [31:0] LPM = 32'h1 << CTL_LP_MODE;
  localparam logic [31:0] OFFH = 32'h1 << CTL_OFFHOOK;
  localparam logic [31:0] RAMP = 32'h1 << CTL_SLOW_RAMP;
  localparam logic [31:0] BTEN = 32'h1 << CTL_BT_EN;
  localparam logic [15:0] RS [5] = '{16'h2000, 16'hE000, 16'h1000, 16'hF000, 16'h0000};
  localparam logic [1:0] RX [5] = '{2'b01, 2'b10, 2'b00, 2'b00, 2'b00};
  localparam logic [15:0] ATT [5] = '{ATT_0DB, ATT_1DB, ATT_2DB2, ATT_3DB5, ATT_5DB};
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, loop_current_level;
  logic [31:0] pwdata, prdata, v;
  logic [11:0] line_peak_mv;
  logic supply_low, ring_sample_valid, offhook_control, dc_term_800, adc_normal_en;
  logic adc_lowpower_en, ring_coupling_reset, full_wave_ring_enable, internal_serial_out, serial_frame;
  logic [15:0] ring_sample;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  line_monitor_billing_cid_control #(.RECOVER_CYCLES(50)) i_line_monitor_billing_cid_control (
    .clk(clk), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_peak_mv(line_peak_mv),
    .supply_low(supply_low), .ring_sample(ring_sample), .ring_sample_valid(ring_sample_valid),
    .offhook_control(offhook_control), .loop_current_level(loop_current_level), .dc_term_800(dc_term_800),
    .adc_normal_en(adc_normal_en), .adc_lowpower_en(adc_lowpower_en), .ring_coupling_reset(ring_coupling_reset),
    .full_wave_ring_enable(full_wave_ring_enable), .internal_serial_out(internal_serial_out),
    .serial_frame(serial_frame));
  host_apb_model i_host_apb_model (.clk(clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================
  // helpers
  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic check_in(input string name, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      failures++;
      $display("MISMATCH %s expected %0h..%0h seen %0h", name, lo, hi, got);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_host_apb_model.write_reg(a, d);
  endtask
  task automatic rreg(input logic [7:0] a);
    i_host_apb_model.read_reg(a, v, e);
  endtask
  task automatic send_sample(input logic [15:0] s);
    @(posedge clk);
    ring_sample <= s;
    ring_sample_valid <= 1'b1;
    @(posedge clk);
    ring_sample_valid <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rreg(ADDR_CTRL);
    check_val("ctrl_reset", 32'h0, v);
    rreg(ADDR_STATUS);
    check_val("status_reset", 32'h0, v);
    rreg(8'h0C);
    check_val("unmapped_err", 32'h1, {31'h0, e});
    check_val("unmapped_data", 32'h0, v);
  endtask
  task automatic t_modes();
    wreg(ADDR_CTRL, MON);
    settle();
    check_val("normal_adc", 32'h1, {31'h0, adc_normal_en});
    check_val("lp_adc_off", 32'h0, {31'h0, adc_lowpower_en});
    i_host_apb_model.cid_start(32'h1 << CTL_FULL_WAVE);
    settle();
    check_val("lp_adc", 32'h1, {31'h0, adc_lowpower_en});
    check_val("normal_off", 32'h0, {31'h0, adc_normal_en});
    check_val("ring_rst", 32'h1, {31'h0, ring_coupling_reset});
    check_val("full_wave", 32'h1, {31'h0, full_wave_ring_enable});
    i_host_apb_model.cid_stop(32'h0);
    settle();
    check_val("lp_adc_clear", 32'h0, {31'h0, adc_lowpower_en});
    check_val("ring_rst_clear", 32'h0, {31'h0, ring_coupling_reset});
  endtask
  task automatic t_ramp();
    wreg(ADDR_CTRL, OFFH | RAMP);
    settle();
    check_val("offhook", 32'h1, {31'h0, offhook_control});
    check_val("loop_full", 32'hFF, {24'h0, loop_current_level});
    wreg(ADDR_CTRL, RAMP);
    settle();
    check_in("ramp_start", 32'hFE, 32'hFF, {24'h0, loop_current_level});
    repeat (1100) @(posedge clk);
    #1;
    check_in("ramp_mid", 32'hFC, 32'hFE, {24'h0, loop_current_level});
    wreg(ADDR_CTRL, OFFH);
    wreg(ADDR_CTRL, 32'h0);
    settle();
    check_val("loop_cut", 32'h0, {24'h0, loop_current_level});
  endtask
  task automatic t_overload();
    @(posedge clk);
    line_peak_mv <= OVERLOAD_MV;
    settle();
    rreg(ADDR_STATUS);
    check_val("rov_at_limit", 32'h0, {31'h0, v[ST_ROV]});
    line_peak_mv <= OVERLOAD_MV + 12'h001;
    settle();
    rreg(ADDR_STATUS);
    check_val("rov_over", 32'h1, {31'h0, v[ST_ROV]});
    check_val("ovl_over", 32'h1, {31'h0, v[ST_OVL]});
    line_peak_mv <= 12'h000;
    settle();
    wreg(ADDR_STATUS, 32'h3);
    rreg(ADDR_STATUS);
    check_val("rov_sticky", 32'h1, {31'h0, v[ST_ROV]});
    check_val("ovl_live", 32'h0, {31'h0, v[ST_OVL]});
    wreg(ADDR_STATUS, 32'h0);
    rreg(ADDR_STATUS);
    check_val("rov_cleared", 32'h0, {31'h0, v[ST_ROV]});
    wreg(ADDR_STATUS, 32'h3);
    rreg(ADDR_STATUS);
    check_val("rov_w1_clear", 32'h0, {31'h0, v[ST_ROV]});
  endtask
  task automatic t_billing();
    @(posedge clk);
    supply_low <= 1'b1;
    settle();
    rreg(ADDR_STATUS);
    check_val("btd_disabled", 32'h0, {31'h0, v[ST_BTD]});
    wreg(ADDR_CTRL, BTEN);
    settle();
    rreg(ADDR_STATUS);
    check_val("btd_set", 32'h1, {31'h0, v[ST_BTD]});
    check_val("term_800", 32'h1, {31'h0, dc_term_800});
    supply_low <= 1'b0;
    i_host_apb_model.billing_release(BTEN);
    repeat (15) @(posedge clk);
    #1;
    check_val("term_recovering", 32'h1, {31'h0, dc_term_800});
    repeat (60) @(posedge clk);
    #1;
    check_val("term_normal", 32'h0, {31'h0, dc_term_800});
    rreg(ADDR_STATUS);
    check_val("btd_sticky", 32'h1, {31'h0, v[ST_BTD]});
    wreg(ADDR_STATUS, 32'h0);
    wreg(ADDR_CTRL, BTEN);
    settle();
    rreg(ADDR_STATUS);
    check_val("btd_reenabled", 32'h0, {31'h0, v[ST_BTD]});
    supply_low <= 1'b1;
    settle();
    rreg(ADDR_STATUS);
    check_val("btd_second", 32'h1, {31'h0, v[ST_BTD]});
    supply_low <= 1'b0;
    wreg(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_serial();
    logic [15:0] w;
    int n;
    n = 0;
    wreg(ADDR_CTRL, MON);
    send_sample(16'h1234);
    while (serial_frame !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (3) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      w[i] = internal_serial_out;
      repeat (8) @(posedge clk);
    end
    check_val("serial_word", 32'h1234, {16'h0, w});
    for (int g = 0; g < 5; g++) begin
      wreg(ADDR_CTRL, MON | LPM | (32'(g) << CTL_GAIN_LSB));
      send_sample(16'h4000);
      repeat (200) @(posedge clk);
      rreg(ADDR_SAMPLE);
      check_in("atten_word", {17'h0, ATT[g][15:1]} - 32'h1, {17'h0, ATT[g][15:1]} + 32'h1, v);
    end
    wreg(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_ring();
    for (int i = 0; i < 5; i++) begin
      send_sample(RS[i]);
      settle();
      rreg(ADDR_STATUS);
      check_val("ring_flags", {30'h0, RX[i]}, {30'h0, v[ST_RDN], v[ST_RDP]});
    end
  endtask

  // ==========================================================
  // clock, watchdog, main sequence
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    arst_n = 1'b0;
    line_peak_mv = 12'h000;
    supply_low = 1'b0;
    ring_sample = 16'h0000;
    ring_sample_valid = 1'b0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_modes();
    t_ramp();
    t_overload();
    t_billing();
    t_serial();
    t_ring();
    final_report();
  end
endmodule

// ---- src/line_monitor_billing_cid_control.sv ----
/*
  Control logic of a line access arrangement: hook and loop current ramp, billing
  tone detector with sticky flags and 800 ohm termination, on-hook monitor ADC
  selection with attenuation, ring detect flags and the serial sample output.
  Assumes synchronous analog-side inputs and an APB master on the same clock.
*/
`timescale 1ns/10ps
// Contract
// - slow-ramp bit set: loop current ramps down gradually at on-hook.
// - billing tone detection only while billing enable bit is set.
// - receive overload flag sets when line signal exceeds 1.1 V peak.
// - detected flag sets on supply droop; termination goes to 800 ohm.
// - both sticky flags hold until host writes zero to them.
// - after disable, normal DC conditions return within about one second.
// - monitor bit enables on-hook ADC, samples forwarded to system side.
// - mode plus monitor bit selects the lower-power monitor ADC.
// - in low-power monitoring gain field selects 0/1/2.2/3.5/5 dB attenuation.
// - ring-coupling reset bit held by host resets ring coupling network.
// - low-power ADC samples delivered over internal serial output.
// - positive flag above threshold, negative below, none between.
module line_monitor_billing_cid_control #(
  parameter int RECOVER_CYCLES = lmon_pkg::RECOVER_CYC,
  parameter logic [15:0] RING_THRESH = 16'h1000
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] line_peak_mv,
  input wire logic supply_low,
  input wire logic [15:0] ring_sample,
  input wire logic ring_sample_valid,
  output logic offhook_control,
  output logic [7:0] loop_current_level,
  output logic dc_term_800,
  output logic adc_normal_en,
  output logic adc_lowpower_en,
  output logic ring_coupling_reset,
  output logic full_wave_ring_enable,
  output logic internal_serial_out,
  output logic serial_frame
);
  import lmon_pkg::*;

  localparam int RCW = $clog2(RECOVER_CYCLES + 1);

  logic [CTRL_W-1:0] ctrl_reg;
  logic receive_overload_flag;
  logic billing_tone_detected_flag;
  logic overload_status;
  logic ring_detect_positive;
  logic ring_detect_negative;
  term_state_t term_reg;
  term_state_t term_next;
  logic [RCW-1:0] recov_cnt_reg;
  logic [15:0] ramp_div_reg;
  logic [7:0] ser_div_reg;
  logic ramp_tick;
  logic ser_tick;
  logic [15:0] samp_reg;
  logic samp_valid_reg;
  logic [15:0] word_reg;
  logic word_valid_reg;
  logic word_ready;
  logic [15:0] last_word_reg;

  logic setup_phase;
  logic wr_fire;
  logic wr_status;
  logic billing_tone_enable;
  logic onhook_monitor_enable;
  logic lp_mode;
  logic rov_set;
  logic btd_set;
  logic signed [15:0] ring_s;

  // ==========================================================
  // helpers
  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_SAMPLE);
  endfunction

  function automatic logic [15:0] attenuate(input logic [15:0] s, input logic [2:0] g);
    logic [15:0] coef;
    logic signed [31:0] prod;
    coef = ATT_0DB;
    prod = 32'sh0;
    case (g)
      3'h1: coef = ATT_1DB;
      3'h2: coef = ATT_2DB2;
      3'h3: coef = ATT_3DB5;
      3'h4: coef = ATT_5DB;
      default: coef = ATT_0DB;
    endcase
    prod = $signed(s) * $signed(coef);
    return prod[30:15];
  endfunction

  assign billing_tone_enable = ctrl_reg[CTL_BT_EN];
  assign onhook_monitor_enable = ctrl_reg[CTL_MON_EN];
  assign lp_mode = ctrl_reg[CTL_LP_MODE];
  assign setup_phase = psel && !penable;
  assign wr_fire = psel && penable && pready && pwrite;
  assign wr_status = wr_fire && (paddr == ADDR_STATUS);
  assign rov_set = line_peak_mv > OVERLOAD_MV;
  assign btd_set = billing_tone_enable && supply_low;
  assign ring_s = $signed(ring_sample);

  // ==========================================================
  // apb slave: no wait states, data sampled at setup
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !addr_known(paddr);
      if (setup_phase) begin
        case (paddr)
          ADDR_CTRL: prdata <= {{(32-CTRL_W){1'b0}}, ctrl_reg};
          ADDR_STATUS: prdata <= {26'h0, term_reg == TERM_RECOVER, ring_detect_negative,
                                  ring_detect_positive, overload_status,
                                  billing_tone_detected_flag, receive_overload_flag};
          ADDR_SAMPLE: prdata <= {16'h0000, last_word_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_fire && (paddr == ADDR_CTRL)) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // billing tone flags; a set in the clear cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      receive_overload_flag <= 1'b0;
      billing_tone_detected_flag <= 1'b0;
      overload_status <= 1'b0;
    end else begin
      overload_status <= rov_set;
      if (rov_set) begin
        receive_overload_flag <= 1'b1;
      end else if (wr_status && !pwdata[ST_ROV]) begin
        receive_overload_flag <= 1'b0;
      end
      if (btd_set) begin
        billing_tone_detected_flag <= 1'b1;
      end else if (wr_status && !pwdata[ST_BTD]) begin
        billing_tone_detected_flag <= 1'b0;
      end
    end
  end

  // ==========================================================
  // dc termination: 800 ohm from detection until billing disable, then timed recovery
  always_comb begin
    term_next = term_reg;
    unique case (term_reg)
      TERM_NORMAL: begin
        if (billing_tone_detected_flag && billing_tone_enable) begin
          term_next = TERM_800;
        end
      end
      TERM_800: begin
        if (!billing_tone_enable) begin
          term_next = TERM_RECOVER;
        end
      end
      TERM_RECOVER: begin
        if (recov_cnt_reg == '0) begin
          term_next = TERM_NORMAL;
        end
      end
      default: term_next = TERM_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      term_reg <= TERM_NORMAL;
      dc_term_800 <= 1'b0;
      recov_cnt_reg <= '0;
    end else begin
      term_reg <= term_next;
      dc_term_800 <= term_next != TERM_NORMAL;
      if (term_reg == TERM_800) begin
        recov_cnt_reg <= RCW'(RECOVER_CYCLES - 1);
      end else if (recov_cnt_reg != '0) begin
        recov_cnt_reg <= recov_cnt_reg - RCW'(1);
      end
    end
  end

  // ==========================================================
  // hook and loop current ramp
  assign ramp_tick = ramp_div_reg == 16'h0000;
  assign ser_tick = ser_div_reg == 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ramp_div_reg <= 16'h0000;
      ser_div_reg <= 8'h00;
    end else begin
      ramp_div_reg <= ramp_tick ? 16'(RAMP_STEP_CYC - 1) : ramp_div_reg - 16'h0001;
      ser_div_reg <= ser_tick ? 8'(SER_BIT_CYC - 1) : ser_div_reg - 8'h01;
    end
  end

  // slow ramp trades hook release time for no inductive spike
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offhook_control <= 1'b0;
      loop_current_level <= LOOP_OFF;
    end else begin
      offhook_control <= ctrl_reg[CTL_OFFHOOK];
      if (ctrl_reg[CTL_OFFHOOK]) begin
        loop_current_level <= LOOP_FULL;
      end else if (!ctrl_reg[CTL_SLOW_RAMP]) begin
        loop_current_level <= LOOP_OFF;
      end else if (ramp_tick && (loop_current_level != LOOP_OFF)) begin
        loop_current_level <= loop_current_level - 8'h01;
      end
    end
  end

  // ==========================================================
  // monitor adc selection and ring network control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_normal_en <= 1'b0;
      adc_lowpower_en <= 1'b0;
      ring_coupling_reset <= 1'b0;
      full_wave_ring_enable <= 1'b0;
    end else begin
      adc_normal_en <= onhook_monitor_enable && !lp_mode;
      adc_lowpower_en <= onhook_monitor_enable && lp_mode;
      ring_coupling_reset <= ctrl_reg[CTL_RING_RST];
      full_wave_ring_enable <= ctrl_reg[CTL_FULL_WAVE];
    end
  end

  // ==========================================================
  // ring detect flags and sample path
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ring_detect_positive <= 1'b0;
      ring_detect_negative <= 1'b0;
      samp_reg <= 16'h0000;
      samp_valid_reg <= 1'b0;
    end else begin
      samp_valid_reg <= ring_sample_valid && !ctrl_reg[CTL_OFFHOOK];
      if (ring_sample_valid) begin
        samp_reg <= ring_sample;
        ring_detect_positive <= ring_s > $signed(RING_THRESH);
        ring_detect_negative <= ring_s < -$signed(RING_THRESH);
      end
    end
  end

  // a word still waiting is replaced by the newer sample
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      word_reg <= 16'h0000;
      word_valid_reg <= 1'b0;
      last_word_reg <= 16'h0000;
    end else begin
      if (samp_valid_reg) begin
        word_valid_reg <= 1'b1;
        if (onhook_monitor_enable && lp_mode) begin
          word_reg <= attenuate(samp_reg, ctrl_reg[CTL_GAIN_LSB +: 3]);
        end else if (onhook_monitor_enable) begin
          word_reg <= samp_reg;
        end else if (ctrl_reg[CTL_FULL_WAVE]) begin
          word_reg <= ring_detect_positive ? CODE_POS :
                      (ring_detect_negative ? CODE_NEG : CODE_FW_IDLE);
        end else begin
          word_reg <= ring_detect_positive ? CODE_POS : CODE_NEG;
        end
      end else if (word_ready) begin
        word_valid_reg <= 1'b0;
        last_word_reg <= word_reg;
      end
    end
  end

  serial_shifter u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .bit_en(ser_tick),
    .word(word_reg),
    .word_valid(word_valid_reg && !samp_valid_reg),
    .word_ready(word_ready),
    .ser_out(internal_serial_out),
    .ser_frame(serial_frame)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence seq_status_write_one_rov;
    wr_status && pwdata[ST_ROV];
  endsequence

  sequence seq_hook_release_slow;
    $fell(offhook_control) && ctrl_reg[CTL_SLOW_RAMP] && !ctrl_reg[CTL_OFFHOOK];
  endsequence

  AST_SLOW_RAMP: assert property (seq_hook_release_slow |-> loop_current_level != LOOP_OFF)
    else $error("loop current cut abruptly with slow ramp set");
  AST_BT_GATED: assert property (!billing_tone_enable && !billing_tone_detected_flag
    |=> !billing_tone_detected_flag)
    else $error("billing tone flag set while detection disabled");
  AST_ROV_SET: assert property (line_peak_mv > OVERLOAD_MV |=> receive_overload_flag
    && overload_status)
    else $error("overload not flagged");
  AST_TERM_800: assert property (billing_tone_detected_flag && billing_tone_enable
    |=> dc_term_800)
    else $error("termination not switched to 800 ohm");
  AST_STICKY: assert property (receive_overload_flag && !wr_status |=> receive_overload_flag)
    else $error("overload flag dropped without a clear");
  AST_RECOVER_END: assert property (term_reg == TERM_RECOVER && recov_cnt_reg == '0
    |=> !dc_term_800 && term_reg == TERM_NORMAL)
    else $error("termination did not recover at count end");
  AST_RECOVER_CNT: assert property (recov_cnt_reg <= RCW'(RECOVER_CYCLES - 1))
    else $error("recovery count beyond one second");
  AST_ADC_SEL: assert property (onhook_monitor_enable |=> adc_lowpower_en == $past(lp_mode)
    && adc_normal_en == !$past(lp_mode))
    else $error("wrong monitor adc selected");
  AST_RING_RST: assert property (ctrl_reg[CTL_RING_RST] |=> ring_coupling_reset)
    else $error("ring coupling reset not driven");
  AST_RING_DET: assert property (ring_sample_valid |=> !(ring_detect_positive && ring_detect_negative)
    && (ring_detect_positive == ($signed(samp_reg) > $signed(RING_THRESH))))
    else $error("ring detect flags wrong");
  AST_W1_IGNORED: assert property (seq_status_write_one_rov ##0 (!receive_overload_flag && !rov_set)
    |=> !receive_overload_flag)
    else $error("write of one set the overload flag");
endmodule

// ---- src/lmon_pkg.sv ----
/*
  Shared constants for the line monitor, billing tone and caller ID control block:
  register offsets, field positions, thresholds, serial codes and timing counts.
  Assumes a 125 MHz system clock and an APB register bus with 32-bit data.
*/
package lmon_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int RECOVER_MS = 1000;
  localparam int RECOVER_CYC = (CLK_HZ / 1000) * RECOVER_MS;
  localparam int RAMP_STEP_NS = 4000;
  localparam int RAMP_STEP_CYC = RAMP_STEP_NS / (1_000_000_000 / CLK_HZ);
  localparam int SER_BIT_NS = 64;
  localparam int SER_BIT_CYC = SER_BIT_NS / (1_000_000_000 / CLK_HZ);

  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SAMPLE = 8'h08;
  localparam int CTRL_W = 11;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
  localparam int CTL_SLOW_RAMP = 0;
  localparam int CTL_BT_EN = 1;
  localparam int CTL_MON_EN = 2;
  localparam int CTL_LP_MODE = 3;
  localparam int CTL_OFFHOOK = 4;
  localparam int CTL_RING_RST = 5;
  localparam int CTL_FULL_WAVE = 6;
  localparam int CTL_GAIN_LSB = 8;
  localparam int ST_ROV = 0;
  localparam int ST_BTD = 1;
  localparam int ST_OVL = 2;
  localparam int ST_RDP = 3;
  localparam int ST_RDN = 4;
  localparam int ST_RECOV = 5;

  // ==========================================================
  // line levels and serial codes
  localparam logic [11:0] OVERLOAD_MV = 12'h44C;
  localparam logic [7:0] LOOP_FULL = 8'hFF;
  localparam logic [7:0] LOOP_OFF = 8'h00;
  localparam logic [15:0] CODE_NEG = 16'h8000;
  localparam logic [15:0] CODE_POS = 16'h7FFF;
  localparam logic [15:0] CODE_FW_IDLE = 16'h04CC;

  // ==========================================================
  // attenuation coefficients, Q15
  localparam logic [15:0] ATT_0DB = 16'h7FFF;
  localparam logic [15:0] ATT_1DB = 16'h7215;
  localparam logic [15:0] ATT_2DB2 = 16'h635B;
  localparam logic [15:0] ATT_3DB5 = 16'h558B;
  localparam logic [15:0] ATT_5DB = 16'h47FA;

  typedef enum logic [2:0] {
    TERM_NORMAL = 3'b001,
    TERM_800 = 3'b010,
    TERM_RECOVER = 3'b100
  } term_state_t;

  typedef enum logic [1:0] {
    SER_IDLE = 2'b01,
    SER_SHIFT = 2'b10
  } ser_state_t;
endpackage

// ---- src/serial_shifter.sv ----
/*
  Shifts one 16-bit word out MSB first on the internal serial output, one bit per
  bit-rate enable pulse, with a frame mark on the first bit.
  Assumes bit_en is a one-cycle pulse from a divider on the same clock.
*/
`timescale 1ns/10ps
module serial_shifter (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic bit_en,
  input wire logic [15:0] word,
  input wire logic word_valid,
  output logic word_ready,
  output logic ser_out,
  output logic ser_frame
);
  import lmon_pkg::*;

  ser_state_t state_reg;
  logic [15:0] shift_reg;
  logic [3:0] cnt_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= SER_IDLE;
      shift_reg <= 16'h0000;
      cnt_reg <= 4'h0;
      ser_out <= 1'b0;
      ser_frame <= 1'b0;
      word_ready <= 1'b0;
    end else begin
      word_ready <= (state_reg == SER_IDLE) && !word_valid;
      unique case (state_reg)
        SER_IDLE: begin
          if (word_valid && word_ready) begin
            shift_reg <= word;
            cnt_reg <= 4'hF;
            state_reg <= SER_SHIFT;
            word_ready <= 1'b0;
          end
        end
        SER_SHIFT: begin
          if (bit_en) begin
            ser_out <= shift_reg[15];
            ser_frame <= (cnt_reg == 4'hF);
            shift_reg <= {shift_reg[14:0], 1'b0};
            cnt_reg <= cnt_reg - 4'h1;
            if (cnt_reg == 4'h0) begin
              state_reg <= SER_IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule
